// ### include/irq_map.svh
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

`define OFS_CONTROL 8'h00
`define OFS_OPTION 8'h04
`define OFS_PFLAGS_A 8'h08
`define OFS_PFLAGS_B 8'h0C
`define OFS_PEN_A 8'h10
`define OFS_PEN_B 8'h14
`define OFS_STATUS 8'h18

`define BIT_GLOBAL_EN 7
`define BIT_GROUP_EN 6
`define BIT_CNT_EN 5
`define BIT_EXT_EN 4
`define BIT_PORT_EN 3
`define BIT_CNT_FLAG 2
`define BIT_EXT_FLAG 1
`define BIT_PORT_FLAG 0
`define BIT_EDGE_SEL 6

`define CONTROL_RESET 8'h00
`define OPTION_RESET 8'hFF
`define VECTOR_ADDR 13'h0004
`define COUNTER_MAX 8'hFF
`define COUNTER_MIN 8'h00
`define Q_LAST 2'h3
`define LAT_BOUNDARIES 2'h3
`define MAX_SOURCES 12
`define CORE_SOURCES 3

`endif

// ### include/irq_pkg.sv
package irq_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_LATENCY,
    ST_SLEEP
  } run_state_t;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;
endpackage

// ### src/core_interrupt_control.sv
// Implementation choices: the address map and the AXI4-Lite slave port.
`include "irq_map.svh"

module core_interrupt_control
  import irq_pkg::*;
#(
  parameter int PA = 8,
  parameter int PB = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_b_pins,
  input wire logic [7:0] eight_bit_counter,
  input wire logic [PA-1:0] periph_event_a,
  input wire logic [PB-1:0] periph_event_b,
  input wire logic return_from_irq_instr,
  input wire logic sleep_instr,
  output logic vector_load,
  output logic push_return,
  output logic [12:0] vector_addr,
  output logic wake_up,
  output logic sleeping,
  output logic irq_pending
);
  // Flags live in byte lane 0 and share the twelve-source budget
  if (PA < 1 || PA > 8 || PB < 1 || PB > 8 ||
      PA + PB + `CORE_SOURCES > `MAX_SOURCES) begin : g_bad_widths
    $error("core_interrupt_control: unsupported peripheral widths");
  end

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] option;
    logic [PA-1:0] pflags_a;
    logic [PB-1:0] pflags_b;
    logic [PA-1:0] pen_a;
    logic [PB-1:0] pen_b;
    logic [7:0] cnt_prev;
    logic [1:0] phase;
    logic [1:0] lat_cnt;
    run_state_t state;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic vector_load;
    logic push_return;
    logic [12:0] vector_addr;
    logic wake_up;
    logic pending;
    logic awready;
    logic wready;
    logic arready;
    logic sleeping;
  } ctl_state_t;

  ctl_state_t s_q, s_d;

  logic [0:0] ext_rise, ext_fall;
  logic [3:0] port_rise, port_fall;

  // External pins arrive asynchronously and pass two flops first
  edge_sync #(.W(1)) u_ext_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(ext_irq_pin),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  edge_sync #(.W(4)) u_port_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(port_b_pins),
    .rise(port_rise),
    .fall(port_fall)
  );

  logic ext_event, port_event, cnt_event, any_enabled, boundary;
  logic wr_fire, rd_fire;
  logic [7:0] rd_addr;

  always_comb begin
    ext_event = s_q.option[`BIT_EDGE_SEL] ? ext_rise[0] : ext_fall[0];
    port_event = |(port_rise | port_fall);
    cnt_event = (s_q.cnt_prev == `COUNTER_MAX) &&
                (eight_bit_counter == `COUNTER_MIN);
    // Gates every source with its own enable, peripherals under the group bit
    any_enabled = (s_q.ctrl[`BIT_CNT_EN] & s_q.ctrl[`BIT_CNT_FLAG]) |
                  (s_q.ctrl[`BIT_EXT_EN] & s_q.ctrl[`BIT_EXT_FLAG]) |
                  (s_q.ctrl[`BIT_PORT_EN] & s_q.ctrl[`BIT_PORT_FLAG]) |
                  (s_q.ctrl[`BIT_GROUP_EN] &
                   (|(s_q.pflags_a & s_q.pen_a) | |(s_q.pflags_b & s_q.pen_b)));
    boundary = (s_q.phase == `Q_LAST);
    wr_fire = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    rd_fire = s_axi_arvalid && !s_q.rvalid;
    rd_addr = s_axi_araddr[7:0];
  end

  always_comb begin
    s_d = s_q;
    s_d.cnt_prev = eight_bit_counter;
    s_d.phase = s_q.phase + 2'h1;
    s_d.vector_load = 1'b0;
    s_d.push_return = 1'b0;
    s_d.wake_up = 1'b0;

    // Write address and data are taken in either order, one write at a time
    if (s_axi_awvalid && !s_q.aw_full) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !s_q.w_full) begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      // Only byte lane 0 holds register bits; other lanes are ignored
      case (s_q.aw_addr)
        `OFS_CONTROL: begin
          if (s_q.w_lane0) begin
            s_d.ctrl = s_q.w_data;
          end
        end
        `OFS_OPTION: begin
          if (s_q.w_lane0) begin
            s_d.option = s_q.w_data;
          end
        end
        `OFS_PFLAGS_A: begin
          if (s_q.w_lane0) begin
            s_d.pflags_a = s_q.w_data[PA-1:0];
          end
        end
        `OFS_PFLAGS_B: begin
          if (s_q.w_lane0) begin
            s_d.pflags_b = s_q.w_data[PB-1:0];
          end
        end
        `OFS_PEN_A: begin
          if (s_q.w_lane0) begin
            s_d.pen_a = s_q.w_data[PA-1:0];
          end
        end
        `OFS_PEN_B: begin
          if (s_q.w_lane0) begin
            s_d.pen_b = s_q.w_data[PB-1:0];
          end
        end
        `OFS_STATUS: begin
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end

    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      case (rd_addr)
        `OFS_CONTROL: s_d.rdata = {24'h0, s_q.ctrl};
        `OFS_OPTION: s_d.rdata = {24'h0, s_q.option};
        `OFS_PFLAGS_A: s_d.rdata = 32'(s_q.pflags_a);
        `OFS_PFLAGS_B: s_d.rdata = 32'(s_q.pflags_b);
        `OFS_PEN_A: s_d.rdata = 32'(s_q.pen_a);
        `OFS_PEN_B: s_d.rdata = 32'(s_q.pen_b);
        `OFS_STATUS: s_d.rdata = {28'h0, s_q.pending, any_enabled,
                                  (s_q.state == ST_LATENCY), (s_q.state == ST_SLEEP)};
        default: begin
          s_d.rdata = 32'h0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Events set flags after any software write, so a set beats a clear
    s_d.ctrl[`BIT_EXT_FLAG] = s_d.ctrl[`BIT_EXT_FLAG] | ext_event;
    s_d.ctrl[`BIT_PORT_FLAG] = s_d.ctrl[`BIT_PORT_FLAG] | port_event;
    s_d.ctrl[`BIT_CNT_FLAG] = s_d.ctrl[`BIT_CNT_FLAG] | cnt_event;
    s_d.pflags_a = s_d.pflags_a | periph_event_a;
    s_d.pflags_b = s_d.pflags_b | periph_event_b;

    if (return_from_irq_instr) begin
      s_d.ctrl[`BIT_GLOBAL_EN] = 1'b1;
    end

    case (s_q.state)
      ST_RUN: begin
        if (s_q.pending) begin
          s_d.state = ST_LATENCY;
          s_d.lat_cnt = 2'h0;
        end else if (sleep_instr) begin
          s_d.state = ST_SLEEP;
        end
      end
      // Vectoring waits for instruction boundaries, which gives the
      // three to four cycle latency whatever the event's phase
      ST_LATENCY: begin
        if (!s_q.pending) begin
          s_d.state = ST_RUN;
        end else if (boundary) begin
          if (s_q.lat_cnt == `LAT_BOUNDARIES - 2'h1) begin
            s_d.state = ST_RUN;
            s_d.vector_load = 1'b1;
            s_d.push_return = 1'b1;
            s_d.vector_addr = `VECTOR_ADDR;
            s_d.ctrl[`BIT_GLOBAL_EN] = 1'b0;
          end else begin
            s_d.lat_cnt = s_q.lat_cnt + 2'h1;
          end
        end
      end
      // Wake ignores the global enable; with it set the run state then vectors
      ST_SLEEP: begin
        if (any_enabled) begin
          s_d.state = ST_RUN;
          s_d.wake_up = 1'b1;
        end
      end
      default: begin
        s_d.state = ST_RUN;
      end
    endcase

    // Readies and the sleep level are registered so every output leaves a flop
    s_d.awready = !s_d.aw_full;
    s_d.wready = !s_d.w_full;
    s_d.arready = !s_d.rvalid;
    s_d.sleeping = (s_d.state == ST_SLEEP);
    s_d.pending = s_d.ctrl[`BIT_GLOBAL_EN] && (s_d.state != ST_SLEEP) &&
                  any_enabled;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl <= `CONTROL_RESET;
      s_q.option <= `OPTION_RESET;
      s_q.state <= ST_RUN;
      s_q.vector_addr <= `VECTOR_ADDR;
      s_q.bresp <= RESP_OKAY;
      s_q.rresp <= RESP_OKAY;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign vector_load = s_q.vector_load;
  assign push_return = s_q.push_return;
  assign vector_addr = s_q.vector_addr;
  assign wake_up = s_q.wake_up;
  assign sleeping = s_q.sleeping;
  assign irq_pending = s_q.pending;

  a_global_en_reset: assert property (@(posedge aclk)
    !aresetn |=> !s_q.ctrl[`BIT_GLOBAL_EN])
    else $error("global enable not cleared by reset");

  a_vector_clears_en: assert property (@(posedge aclk) disable iff (!aresetn)
    vector_load |-> !s_q.ctrl[`BIT_GLOBAL_EN] && push_return && vector_addr == `VECTOR_ADDR)
    else $error("vector taken without clearing enable or pushing");

  a_vector_needs_en: assert property (@(posedge aclk) disable iff (!aresetn)
    vector_load |-> $past(s_q.ctrl[`BIT_GLOBAL_EN]) && $past(irq_pending))
    else $error("vector taken while blocked");

  a_return_sets_en: assert property (@(posedge aclk) disable iff (!aresetn)
    return_from_irq_instr |=> s_q.ctrl[`BIT_GLOBAL_EN] || vector_load)
    else $error("return did not set global enable");

  a_counter_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_event |=> s_q.ctrl[`BIT_CNT_FLAG])
    else $error("rollover did not set flag");

  a_edge_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_rise[0] && s_q.option[`BIT_EDGE_SEL] |=> s_q.ctrl[`BIT_EXT_FLAG])
    else $error("rising edge did not set flag");

  a_fall_edge_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_fall[0] && !s_q.option[`BIT_EDGE_SEL] |=> s_q.ctrl[`BIT_EXT_FLAG])
    else $error("falling edge did not set flag");

  a_port_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    port_event |=> s_q.ctrl[`BIT_PORT_FLAG])
    else $error("port change did not set flag");

  a_wake_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && any_enabled |=> wake_up && !sleeping)
    else $error("enabled flag did not wake");

  a_vector_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq_pending) && !vector_load |-> ##[9:14] vector_load or
      ##[1:14] !irq_pending)
    else $error("vector latency out of range");

  // Only a write landing on the wake edge may have cleared the waking flag
  a_wake_leaves_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_up |-> (|s_q.ctrl[`BIT_CNT_FLAG:`BIT_PORT_FLAG]) || (|s_q.pflags_a) ||
      (|s_q.pflags_b) || $past(wr_fire))
    else $error("wake without a set flag");
endmodule // core_interrupt_control

// ### src/edge_sync.sv
module edge_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  if (W < 1) begin : g_bad_width
    $error("edge_sync: width must be at least one");
  end

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] last;
    logic [1:0] fill;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } sync_state_t;

  sync_state_t s_q, s_d;

  // Edges are held off until the history register holds a real pin level
  always_comb begin
    s_d = s_q;
    s_d.meta = din;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
    if (s_q.fill != 2'h3) begin
      s_d.fill = s_q.fill + 2'h1;
    end
    s_d.rise = (s_q.fill == 2'h3) ? (s_q.sync & ~s_q.last) : '0;
    s_d.fall = (s_q.fill == 2'h3) ? (~s_q.sync & s_q.last) : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise = s_q.rise;
  assign fall = s_q.fall;
endmodule // edge_sync

// ### tb/core_interrupt_control_tb_top.sv
`include "irq_map.svh"

module core_interrupt_control_tb_top
  import irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] aw_a = 32'h0, w_d = 32'h0, ar_a = 32'h0, r_d;
  logic aw_v = 1'h0, w_v = 1'h0, ar_v = 1'h0, aw_r, w_r, ar_r, b_v, r_v;
  logic [1:0] b_s, r_s;
  logic ext_pin = 1'h0, ret_req = 1'h0, sleep_req = 1'h0, rfi, slp;
  logic [3:0] pins = 4'h0, ws = 4'hF;
  logic pev_b = 1'h0;
  logic [7:0] cnt = 8'h00, pev_a = 8'h00;
  logic vector_load, push_return, wake_up, sleeping, irq_pending;
  logic [12:0] vector_addr, pc;
  int n_errors = 0, n_compared = 0, n;

  always #25 aclk = ~aclk;

  core_interrupt_control #(.PA(8), .PB(1)) core_interrupt_control_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(ws), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(1'h1),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(1'h1),
    .ext_irq_pin(ext_pin), .port_b_pins(pins), .eight_bit_counter(cnt),
    .periph_event_a(pev_a), .periph_event_b(pev_b),
    .return_from_irq_instr(rfi), .sleep_instr(slp),
    .vector_load(vector_load), .push_return(push_return), .vector_addr(vector_addr),
    .wake_up(wake_up), .sleeping(sleeping), .irq_pending(irq_pending)
  );

  core_model core_model_i (
    .aclk(aclk), .aresetn(aresetn), .vector_load(vector_load),
    .push_return(push_return), .vector_addr(vector_addr), .wake_up(wake_up),
    .ret_req(ret_req), .sleep_req(sleep_req),
    .return_from_irq_instr(rfi), .sleep_instr(slp), .pc(pc)
  );

  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang();
    n_errors++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
    end_of_test();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // bready is held high throughout, which any slave must accept
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    aw_a <= {24'h0, a};
    w_d <= d;
    aw_v <= 1'h1;
    w_v <= 1'h1;
    for (t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (aw_v && aw_r) aw_v <= 1'h0;
      if (w_v && w_r) w_v <= 1'h0;
      if (b_v) break;
    end
    if (t == 50) hang();
    chk({30'h0, b_s}, {30'h0, er});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int t;
    ar_a <= {24'h0, a};
    ar_v <= 1'h1;
    for (t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (ar_v && ar_r) ar_v <= 1'h0;
      if (r_v) break;
    end
    if (t == 50) hang();
    chk(r_d, exp);
    chk({30'h0, r_s}, {30'h0, er});
  endtask

  task automatic wfor(ref logic s, input int lim, output int k);
    for (k = 1; k <= lim; k++) begin
      @(posedge aclk);
      if (s === 1'h1) break;
    end
    if (k > lim) hang();
  endtask

  task automatic pulse_a(input logic [7:0] v);
    pev_a <= v;
    @(posedge aclk);
    pev_a <= 8'h00;
  endtask

  task automatic pulse_sleep();
    sleep_req <= 1'h1;
    @(posedge aclk);
    sleep_req <= 1'h0;
    cyc(2);
  endtask

  initial begin
    cyc(5);
    aresetn <= 1'h1;
    cyc(4);
    rchk(`OFS_CONTROL, 32'h00, RESP_OKAY);
    rchk(`OFS_OPTION, 32'hFF, RESP_OKAY);
    chk({19'h0, vector_addr}, 32'h0004);
    rchk(8'h1C, 32'h00, RESP_SLVERR);
    wr(`OFS_STATUS, 32'hFF, RESP_OKAY);
    rchk(`OFS_STATUS, 32'h00, RESP_OKAY);
    cnt <= 8'hFF;
    cyc(1);
    cnt <= 8'h00;
    pins <= 4'h8;
    ext_pin <= 1'h1;
    cyc(6);
    rchk(`OFS_CONTROL, 32'h07, RESP_OKAY);
    pulse_a(8'h81);
    cyc(1);
    rchk(`OFS_PFLAGS_A, 32'h81, RESP_OKAY);
    pev_b <= 1'h1;
    cyc(1);
    pev_b <= 1'h0;
    rchk(`OFS_PFLAGS_B, 32'h01, RESP_OKAY);
    wr(`OFS_PFLAGS_B, 32'h00, RESP_OKAY);
    // Lane 0 strobe low: the write is answered but must not land
    ws <= 4'hE;
    wr(`OFS_PEN_B, 32'h01, RESP_OKAY);
    ws <= 4'hF;
    rchk(`OFS_PEN_B, 32'h00, RESP_OKAY);
    wr(`OFS_PFLAGS_A, 32'h00, RESP_OKAY);
    wr(`OFS_CONTROL, 32'h00, RESP_OKAY);
    wr(`OFS_OPTION, 32'hBF, RESP_OKAY);
    ext_pin <= 1'h0;
    cyc(6);
    rchk(`OFS_CONTROL, 32'h02, RESP_OKAY);
    wr(`OFS_CONTROL, 32'h00, RESP_OKAY);
    ext_pin <= 1'h1;
    cyc(6);
    rchk(`OFS_CONTROL, 32'h00, RESP_OKAY);
    wr(`OFS_CONTROL, 32'h90, RESP_OKAY);
    // Three to four instruction cycles of four clocks, plus pin sync and sampling
    ext_pin <= 1'h0;
    wfor(vector_load, 40, n);
    chk({31'h0, n >= 12 && n <= 20}, 32'h1);
    cyc(1);
    chk({19'h0, pc}, 32'h0004);
    rchk(`OFS_CONTROL, 32'h12, RESP_OKAY);
    wr(`OFS_CONTROL, 32'h10, RESP_OKAY);
    ret_req <= 1'h1;
    cyc(1);
    ret_req <= 1'h0;
    cyc(2);
    rchk(`OFS_CONTROL, 32'h90, RESP_OKAY);
    chk({19'h0, pc}, 32'h0100);
    wr(`OFS_PEN_A, 32'h01, RESP_OKAY);
    wr(`OFS_CONTROL, 32'h80, RESP_OKAY);
    pulse_a(8'h01);
    cyc(20);
    chk({31'h0, irq_pending}, 32'h0);
    wr(`OFS_CONTROL, 32'hC0, RESP_OKAY);
    wfor(vector_load, 40, n);
    wr(`OFS_PFLAGS_A, 32'h00, RESP_OKAY);
    rchk(`OFS_CONTROL, 32'h40, RESP_OKAY);
    pulse_sleep();
    chk({31'h0, sleeping}, 32'h1);
    pulse_a(8'h01);
    wfor(wake_up, 20, n);
    cyc(30);
    chk({31'h0, sleeping}, 32'h0);
    chk({19'h0, pc}, 32'h0005);
    rchk(`OFS_PFLAGS_A, 32'h01, RESP_OKAY);
    wr(`OFS_PFLAGS_A, 32'h00, RESP_OKAY);
    wr(`OFS_CONTROL, 32'hC0, RESP_OKAY);
    pulse_sleep();
    pulse_a(8'h01);
    wfor(wake_up, 20, n);
    wfor(vector_load, 40, n);
    cyc(1);
    chk({19'h0, pc}, 32'h0004);
    wr(`OFS_CONTROL, 32'h80, RESP_OKAY);
    rchk(`OFS_CONTROL, 32'h80, RESP_OKAY);
    aresetn <= 1'h0;
    cyc(2);
    aresetn <= 1'h1;
    cyc(4);
    rchk(`OFS_CONTROL, 32'h00, RESP_OKAY);
    rchk(`OFS_OPTION, 32'hFF, RESP_OKAY);
    end_of_test();
  end

  initial begin
    #2000000;
    hang();
  end
endmodule // core_interrupt_control_tb_top

// ### tb/core_model.sv
module core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic vector_load,
  input wire logic push_return,
  input wire logic [12:0] vector_addr,
  input wire logic wake_up,
  input wire logic ret_req,
  input wire logic sleep_req,
  output logic return_from_irq_instr,
  output logic sleep_instr,
  output logic [12:0] pc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] stack_q;

  // Core side: only the return PC is stacked, context is left to software
  always @(posedge aclk) begin
    return_from_irq_instr <= ret_req & aresetn;
    sleep_instr <= sleep_req & aresetn;
    if (!aresetn) begin
      pc <= 13'h0100;
    end else if (vector_load && push_return) begin
      stack_q <= pc;
      pc <= vector_addr;
    end else if (ret_req) begin
      pc <= stack_q;
    end else if (sleep_req) begin
      // Next instruction is prefetched, so a plain wake resumes there
      pc <= pc + 13'h0001;
    end
  end
endmodule // core_model
